// ===== tfs_regs.svh
`ifndef TFS_REGS_SVH
`define TFS_REGS_SVH

// register byte offsets
`define TFS_OFS_INT_CTRL2 8'h00
`define TFS_OFS_FLAGS 8'h04
`define TFS_OFS_IRQ_STATUS 8'h08
`define TFS_OFS_IRQ_MASK 8'h0C

// interrupt_control_second fields
`define TFS_BIT_T4_EN 3
`define TFS_BIT_T5_EN 1
`define TFS_INT_CTRL2_W 4
`define TFS_INT_CTRL2_RST 4'h0

// request flag positions (flags register and flag vector)
`define TFS_FLAG_T4 0
`define TFS_FLAG_T5 1
`define TFS_FLAG_SIO 2
`define TFS_FLAG_SKIP 3
`define TFS_FLAG_W 3

// interrupt status / mask positions
`define TFS_IRQ_T4_SKIP 0
`define TFS_IRQ_T5_SKIP 1
`define TFS_IRQ_SIO_START 2
`define TFS_IRQ_SIO_DONE 3
`define TFS_IRQ_W 4
`define TFS_IRQ_MASK_RST 4'h0

// instruction words
`define TFS_OPC_SKIP_T5 10'h284
`define TFS_OPC_SIO_START 10'h29E

`endif

// ===== tfs_pkg.sv
package tfs_pkg;

  typedef enum logic [1:0] {
    TFS_OP_NONE = 2'b00,
    TFS_OP_SKIP_T4 = 2'b01,
    TFS_OP_SKIP_T5 = 2'b10,
    TFS_OP_SIO_START = 2'b11
  } tfs_op_e;

  typedef enum logic [1:0] {
    TFS_BUS_IDLE = 2'b00,
    TFS_BUS_WRITE = 2'b01,
    TFS_BUS_READ = 2'b10
  } tfs_bus_e;

endpackage

// ===== tfs_sticky.sv
`timescale 1ns/100ps

// sticky flag bank: a set in the same cycle as a clear wins
module tfs_sticky #(
  parameter int W = 1
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] q_o
);

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      q_o <= '0;
    end
    else
    begin
      q_o <= (q_o & ~clr_i) | set_i;
    end
  end

endmodule

// ===== tfs_skip_test.sv
`timescale 1ns/100ps

// one timer flag test: skip and clear only while the enable bit is low
module tfs_skip_test (
  input wire logic exec_i,
  input wire logic enable_bit_i,
  input wire logic flag_i,
  output logic skip_o,
  output logic clear_o
);

  // enable high turns the test into a plain no-operation
  assign skip_o = exec_i & ~enable_bit_i & flag_i;
  assign clear_o = skip_o;

endmodule

// ===== tfs_timer_flag_skip.sv
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`include "tfs_regs.svh"

module tfs_timer_flag_skip #(
  parameter logic [9:0] SKIP_T4_OPCODE = 10'h283
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  // instruction sequencer
  input wire logic instr_valid_i,
  input wire logic [9:0] instr_code_i,
  output logic skip_next_o,
  output logic nop_cycle_o,
  output tfs_pkg::tfs_op_e last_op_o,
  // timer and serial units
  input wire logic timer4_event_i,
  input wire logic timer5_event_i,
  input wire logic serial_done_event_i,
  output logic timer4_request_flag_o,
  output logic timer5_request_flag_o,
  output logic serial_done_flag_o,
  output logic serial_start_o,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic irq_o
);

  import tfs_pkg::*;

  logic [`TFS_INT_CTRL2_W-1:0] interrupt_control_second;
  logic [`TFS_IRQ_W-1:0] irq_mask;
  logic [`TFS_IRQ_W-1:0] irq_status;
  logic [`TFS_IRQ_W-1:0] irq_set;
  logic [`TFS_IRQ_W-1:0] irq_clr;
  logic [`TFS_FLAG_W-1:0] flags;
  logic [`TFS_FLAG_W-1:0] flag_set;
  logic [`TFS_FLAG_W-1:0] flag_clr;
  logic timer4_irq_enable_bit;
  logic timer5_irq_enable_bit;
  logic skip_pending;
  logic exec;
  tfs_op_e op;
  logic skip_on_timer4_request;
  logic skip_on_timer5_request;
  logic serial_transfer_start_op;
  logic t4_skip;
  logic t4_clear;
  logic t5_skip;
  logic t5_clear;
  tfs_bus_e bus_state;
  tfs_bus_e next_bus_state;
  logic [7:0] bus_addr;
  logic addr_phase;
  logic [7:0] addr_ofs;
  logic [31:0] next_rdata;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;

  // ---------------- instruction decode ----------------

  // an instruction that follows a taken skip is swallowed here, so a
  // swallowed serial start or flag test has no effect at all
  assign exec = instr_valid_i & ~skip_pending;

  always_comb
  begin
    op = TFS_OP_NONE;
    if (exec)
    begin
      case (instr_code_i)
        SKIP_T4_OPCODE:
        begin
          op = TFS_OP_SKIP_T4;
        end
        `TFS_OPC_SKIP_T5:
        begin
          op = TFS_OP_SKIP_T5;
        end
        `TFS_OPC_SIO_START:
        begin
          op = TFS_OP_SIO_START;
        end
        default:
        begin
          op = TFS_OP_NONE;
        end
      endcase
    end
  end

  assign skip_on_timer4_request = (op == TFS_OP_SKIP_T4);
  assign skip_on_timer5_request = (op == TFS_OP_SKIP_T5);
  assign serial_transfer_start_op = (op == TFS_OP_SIO_START);

  assign timer4_irq_enable_bit =
    interrupt_control_second[`TFS_BIT_T4_EN];
  assign timer5_irq_enable_bit =
    interrupt_control_second[`TFS_BIT_T5_EN];

  tfs_skip_test u_t4_test (
    .exec_i(skip_on_timer4_request),
    .enable_bit_i(timer4_irq_enable_bit),
    .flag_i(flags[`TFS_FLAG_T4]),
    .skip_o(t4_skip),
    .clear_o(t4_clear)
  );

  tfs_skip_test u_t5_test (
    .exec_i(skip_on_timer5_request),
    .enable_bit_i(timer5_irq_enable_bit),
    .flag_i(flags[`TFS_FLAG_T5]),
    .skip_o(t5_skip),
    .clear_o(t5_clear)
  );

  // handshake towards the sequencer: skip in the same cycle as the test, nop on the swallowed instruction
  assign skip_next_o = t4_skip | t5_skip;
  assign nop_cycle_o = instr_valid_i & skip_pending;

  // a skip arms the kill for exactly the next valid instruction
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      skip_pending <= 1'b0;
    end
    else if (skip_next_o)
    begin
      skip_pending <= 1'b1;
    end
    else if (instr_valid_i)
    begin
      skip_pending <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      last_op_o <= TFS_OP_NONE;
    end
    else if (exec)
    begin
      last_op_o <= op;
    end
  end

  // ---------------- request flags ----------------

  // a fresh timer event in the clearing cycle keeps the flag set
  always_comb
  begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[`TFS_FLAG_T4] = timer4_event_i;
    flag_set[`TFS_FLAG_T5] = timer5_event_i;
    flag_set[`TFS_FLAG_SIO] = serial_done_event_i;
    flag_clr[`TFS_FLAG_T4] = t4_clear;
    flag_clr[`TFS_FLAG_T5] = t5_clear;
    flag_clr[`TFS_FLAG_SIO] = serial_transfer_start_op;
  end

  tfs_sticky #(
    .W(`TFS_FLAG_W)
  ) u_flags (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .set_i(flag_set),
    .clr_i(flag_clr),
    .q_o(flags)
  );

  assign timer4_request_flag_o = flags[`TFS_FLAG_T4];
  assign timer5_request_flag_o = flags[`TFS_FLAG_T5];
  assign serial_done_flag_o = flags[`TFS_FLAG_SIO];

  // one-cycle start strobe to the serial unit
  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      serial_start_o <= 1'b0;
    end
    else
    begin
      serial_start_o <= serial_transfer_start_op;
    end
  end

  // ---------------- AHB-Lite slave ----------------

  // zero wait states: read data is fetched in the address phase
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign addr_phase = hsel_i & htrans_i[1] & hready_i;
  assign addr_ofs = {haddr_i[7:2], 2'b00};

  always_comb
  begin
    next_bus_state = TFS_BUS_IDLE;
    case ({addr_phase, hwrite_i})
      2'b11:
      begin
        next_bus_state = TFS_BUS_WRITE;
      end
      2'b10:
      begin
        next_bus_state = TFS_BUS_READ;
      end
      default:
      begin
        next_bus_state = TFS_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      bus_state <= TFS_BUS_IDLE;
      bus_addr <= 8'h00;
    end
    else if (hready_i)
    begin
      bus_state <= next_bus_state;
      bus_addr <= addr_ofs;
    end
  end

  // upper address bits are not decoded; the block aliases every 256 bytes
  // a read pipelined right behind a write still sees the value before it
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (addr_ofs)
      `TFS_OFS_INT_CTRL2:
      begin
        next_rdata[`TFS_INT_CTRL2_W-1:0] = interrupt_control_second;
      end
      `TFS_OFS_FLAGS:
      begin
        next_rdata[`TFS_FLAG_W-1:0] = flags;
        next_rdata[`TFS_FLAG_SKIP] = skip_pending;
      end
      `TFS_OFS_IRQ_STATUS:
      begin
        next_rdata[`TFS_IRQ_W-1:0] = irq_status;
      end
      `TFS_OFS_IRQ_MASK:
      begin
        next_rdata[`TFS_IRQ_W-1:0] = irq_mask;
      end
      default:
      begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      hrdata_o <= 32'h0000_0000;
    end
    else if (addr_phase && !hwrite_i)
    begin
      hrdata_o <= next_rdata;
    end
  end

  assign wr_ctrl = (bus_state == TFS_BUS_WRITE) &&
    (bus_addr == `TFS_OFS_INT_CTRL2);
  assign wr_status = (bus_state == TFS_BUS_WRITE) &&
    (bus_addr == `TFS_OFS_IRQ_STATUS);
  assign wr_mask = (bus_state == TFS_BUS_WRITE) &&
    (bus_addr == `TFS_OFS_IRQ_MASK);

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      interrupt_control_second <= `TFS_INT_CTRL2_RST;
    end
    else if (wr_ctrl)
    begin
      interrupt_control_second <= hwdata_i[`TFS_INT_CTRL2_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      irq_mask <= `TFS_IRQ_MASK_RST;
    end
    else if (wr_mask)
    begin
      irq_mask <= hwdata_i[`TFS_IRQ_W-1:0];
    end
  end

  // ---------------- interrupt status ----------------

  always_comb
  begin
    irq_set = '0;
    irq_set[`TFS_IRQ_T4_SKIP] = t4_skip;
    irq_set[`TFS_IRQ_T5_SKIP] = t5_skip;
    irq_set[`TFS_IRQ_SIO_START] = serial_transfer_start_op;
    irq_set[`TFS_IRQ_SIO_DONE] = serial_done_event_i;
    irq_clr = wr_status ? hwdata_i[`TFS_IRQ_W-1:0] : '0;
  end

  tfs_sticky #(
    .W(`TFS_IRQ_W)
  ) u_irq (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .set_i(irq_set),
    .clr_i(irq_clr),
    .q_o(irq_status)
  );

  assign irq_o = |(irq_status & irq_mask);

endmodule

// ===== tfs_timer_flag_skip_monitor.sv
`timescale 1ns/100ps
`include "tfs_regs.svh"

module tfs_monitor #(
  parameter logic [9:0] T4_OP = 10'h283
) (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic instr_valid_i,
  input wire logic [9:0] instr_code_i,
  input wire logic skip_next_o,
  input wire logic nop_cycle_o,
  input wire logic timer4_event_i,
  input wire logic timer5_event_i,
  input wire logic serial_done_event_i,
  input wire logic timer4_request_flag_o,
  input wire logic timer5_request_flag_o,
  input wire logic serial_done_flag_o,
  input wire logic serial_start_o
);
  logic ex;
  logic sio_d;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  assign ex = instr_valid_i && !nop_cycle_o;
  always_ff @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
      sio_d <= 1'b0;
    else
      sio_d <= ex && instr_code_i == `TFS_OPC_SIO_START;
  sequence s_t4;
    ex && instr_code_i == T4_OP;
  endsequence
  sequence s_t5;
    ex && instr_code_i == `TFS_OPC_SKIP_T5;
  endsequence
  sequence s_sio;
    ex && instr_code_i == `TFS_OPC_SIO_START;
  endsequence
  property p_t4_skip;
    s_t4 ##0 skip_next_o |=> timer4_request_flag_o == $past(timer4_event_i);
  endproperty
  a_t4_skip: assert property (p_t4_skip)
    else $error("t4 not cleared");
  property p_t4_keep;
    s_t4 ##0 !skip_next_o |=> timer4_request_flag_o ==
      ($past(timer4_request_flag_o) | $past(timer4_event_i));
  endproperty
  a_t4_keep: assert property (p_t4_keep)
    else $error("t4 flag lost");
  property p_t4_need;
    s_t4 ##0 !timer4_request_flag_o |-> !skip_next_o;
  endproperty
  a_t4_need: assert property (p_t4_need)
    else $error("t4 bad skip");
  property p_t5_skip;
    s_t5 ##0 skip_next_o |=> timer5_request_flag_o == $past(timer5_event_i);
  endproperty
  a_t5_skip: assert property (p_t5_skip)
    else $error("t5 not cleared");
  property p_t5_keep;
    s_t5 ##0 !skip_next_o |=> timer5_request_flag_o ==
      ($past(timer5_request_flag_o) | $past(timer5_event_i));
  endproperty
  a_t5_keep: assert property (p_t5_keep)
    else $error("t5 flag lost");
  property p_t5_need;
    s_t5 ##0 !timer5_request_flag_o |-> !skip_next_o;
  endproperty
  a_t5_need: assert property (p_t5_need)
    else $error("t5 bad skip");
  property p_sio;
    s_sio |=> serial_start_o &&
      serial_done_flag_o == $past(serial_done_event_i);
  endproperty
  a_sio: assert property (p_sio)
    else $error("serial start wrong");
  property p_start;
    serial_start_o |-> sio_d;
  endproperty
  a_start: assert property (p_start)
    else $error("stray start");
  property p_nop;
    skip_next_o ##1 instr_valid_i |-> nop_cycle_o ##1 !serial_start_o;
  endproperty
  a_nop: assert property (p_nop)
    else $error("skip not a nop");
endmodule

// ===== tfs_timer_flag_skip_tb.sv
`timescale 1ns/100ps
`include "tfs_regs.svh"

module tfs_timer_flag_skip_tb;
  import tfs_pkg::*;
  localparam logic [9:0] T4_OP = 10'h283;
  logic core_clk_i = 0, reset_i = 1, instr_valid_i = 0;
  logic [9:0] instr_code_i = 0;
  logic timer4_event_i = 0, timer5_event_i = 0, serial_done_event_i = 0;
  logic hsel_i = 0, hwrite_i = 0, hready_i;
  logic [1:0] htrans_i = 0;
  logic [2:0] hsize_i = 0;
  logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd, r;
  logic skip_next_o, nop_cycle_o, t4f, t5f, sdf, serial_start_o;
  logic hreadyout_o, hresp_o, irq_o, f4 = 0, f5 = 0, fs = 0, ex;
  logic [3:0] st = 0, ctl;
  tfs_op_e last_op_o;
  int n_mismatch = 0, checked = 0;
  assign hready_i = hreadyout_o;
  tfs_timer_flag_skip #(.SKIP_T4_OPCODE(T4_OP)) u_tfs_timer_flag_skip (
    .core_clk_i, .reset_i, .instr_valid_i, .instr_code_i, .skip_next_o,
    .nop_cycle_o, .last_op_o, .timer4_event_i, .timer5_event_i,
    .serial_done_event_i, .timer4_request_flag_o(t4f),
    .timer5_request_flag_o(t5f), .serial_done_flag_o(sdf), .serial_start_o,
    .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i,
    .hrdata_o, .hreadyout_o, .hresp_o, .irq_o);
  initial
  begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic print_verdict;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic tfs_op_e exp_op(input logic t5, input logic sk);
    if (!sk)
      return TFS_OP_SIO_START;
    return t5 ? TFS_OP_SKIP_T5 : TFS_OP_SKIP_T4;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1;
    htrans_i <= 2'b10;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    hsize_i <= 3'b010;
    @(posedge core_clk_i);
    while (hready_i !== 1'b1)
      @(posedge core_clk_i);
    htrans_i <= 0;
    hwdata_i <= d;
    @(posedge core_clk_i);
    while (hready_i !== 1'b1)
      @(posedge core_clk_i);
    rd = hrdata_o;
    chk("hresp", 0, hresp_o);
  endtask
  // the other enable bit is set opposite so a swapped bit shows up
  task automatic run_case(input logic t5, en, fl, dn);
    ctl = 4'h0;
    ctl[t5 ? 1 : 3] = en;
    ctl[t5 ? 3 : 1] = !en;
    @(posedge core_clk_i);
    ahb(1, 8'h00, {28'h0, ctl});
    timer4_event_i <= fl & !t5;
    timer5_event_i <= fl & t5;
    serial_done_event_i <= dn;
    @(posedge core_clk_i);
    timer4_event_i <= 0;
    timer5_event_i <= 0;
    serial_done_event_i <= 0;
    instr_valid_i <= 1;
    instr_code_i <= t5 ? `TFS_OPC_SKIP_T5 : T4_OP;
    if (t5) f5 |= fl;
    else f4 |= fl;
    fs |= dn;
    ex = (t5 ? f5 : f4) & !en;
    #1;
    if (t5)
      chk("t5_skip", ex, skip_next_o);
    else
      chk("t4_skip", ex, skip_next_o);
    if (ex && t5) f5 = 0;
    if (ex && !t5) f4 = 0;
    @(posedge core_clk_i);
    instr_code_i <= `TFS_OPC_SIO_START;
    #1;
    chk("t4_flag", f4, t4f);
    chk("t5_flag", f5, t5f);
    chk("nop_cycle", ex, nop_cycle_o);
    @(posedge core_clk_i);
    instr_valid_i <= 0;
    if (!ex) fs = 0;
    st |= {dn, !ex, ex & t5, ex & !t5};
    #1;
    chk("serial_start", !ex, serial_start_o);
    chk("serial_done", fs, sdf);
    chk("last_op", exp_op(t5, ex), last_op_o);
  endtask
  initial
  begin
    void'($urandom(32'h09D89903));
    repeat (16) @(posedge core_clk_i);
    reset_i <= 0;
    @(posedge core_clk_i);
    ahb(0, 8'h00, 0);
    chk("ctl_reset", 0, rd);
    ahb(0, 8'h40, 0);
    chk("unmapped", 0, rd);
    ahb(1, 8'h0C, 32'hF);
    for (int i = 0; i < 48; i++)
    begin
      r = (i < 16) ? i : $urandom;
      run_case(r[0], r[1], r[2], r[3]);
    end
    $display("test flag_skip done");
    @(posedge core_clk_i);
    ahb(0, 8'h04, 0);
    chk("flags_reg", {29'h0, fs, f5, f4}, rd);
    ahb(0, 8'h00, 0);
    chk("ctl_read", {28'h0, ctl}, rd);
    ahb(0, 8'h08, 0);
    chk("irq_status", {28'h0, st}, rd);
    chk("irq", |st, irq_o);
    ahb(1, 8'h0C, 0);
    #1;
    chk("irq_masked", 0, irq_o);
    @(posedge core_clk_i);
    ahb(1, 8'h08, {28'h0, st});
    ahb(0, 8'h08, 0);
    chk("irq_cleared", 0, rd);
    $display("test irq done");
    print_verdict();
  end
  initial
  begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
endmodule

bind tfs_timer_flag_skip tfs_monitor #(.T4_OP(SKIP_T4_OPCODE))
  u_tfs_monitor (
  .core_clk_i, .reset_i, .instr_valid_i, .instr_code_i, .skip_next_o,
  .nop_cycle_o, .timer4_event_i, .timer5_event_i, .serial_done_event_i,
  .timer4_request_flag_o, .timer5_request_flag_o, .serial_done_flag_o,
  .serial_start_o);
